// ### kri_ctrl.sv
// Key return detector and interrupt source unit.
// Assumes an Avalon-MM master with 16-bit byte addresses, 8-bit data,
// a core that acknowledges one request at a time, and pins that are
// asynchronous to clk.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
// Overview of operation
// - Mode pin high: key edge raises NMI
// - Key zero falling edge detected alone
// - Keys one to four ORed, falling edge
// - Key five edge chosen by select bit
// - Mode low in stop: key edge resets
// - Mode low outside stop: NMI still
// - Cause bit marks key return reset
// - Key reset keeps select, sets cause
// - NMI unconditional, beats all maskable requests
// - Every request raises standby release
// - Maskable served by fixed priority zero first
// - Key NMI vector is 0002
// - Watchdog vector 0004, mode picks type
// - Pin edges priorities one, two
// - Timer requests priorities three to six
// - Serial requests priorities seven and eight
// - Low voltage nine, memory write ten
// - Thirteen sources, eleven maskable
// - Acknowledge clears matching request flag
// - Reset masks every maskable source
module kri_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic key_reset_seen, // High for the reset the key circuit made
  // Avalon-MM slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // Key pins
  input wire logic key_return_mode_pin,
  input wire logic key_input_zero,
  input wire logic key_input_one,
  input wire logic key_input_two,
  input wire logic key_input_three,
  input wire logic key_input_four,
  input wire logic key_input_five,
  input wire logic stop_mode,
  // Maskable request pulses from peripherals
  input wire logic watchdog_overflow_request,
  input wire logic pin_edge_request_zero,
  input wire logic pin_edge_request_one,
  input wire logic timer_d_match_request,
  input wire logic timer0_channel0_request,
  input wire logic timer0_channel1_request,
  input wire logic timer5_match_request,
  input wire logic serial_receive_done_request,
  input wire logic serial_3wire_done_request,
  input wire logic serial_transmit_done_request,
  input wire logic low_voltage_detect_request,
  input wire logic nvm_write_done_request,
  // Core side
  input wire logic int_ack,
  input wire logic int_enable,
  output logic int_req,
  output logic [15:0] int_vector,
  output logic standby_release,
  output logic key_reset_out
);
  // ==========================================================
  // Key synchronisation
  logic [5:0] key_sync; // Synchronised keys
  logic [5:0] key_pins;
  logic [1:0] mode_sync; // Mode pin and stop level, synchronised
  logic [1:0] mode_pins;

  assign key_pins = {key_input_five, key_input_four, key_input_three,
                     key_input_two, key_input_one, key_input_zero};
  assign mode_pins = {stop_mode, key_return_mode_pin};

  // Key pins through two flops
  kri_sync #(.WIDTH(6)) u_key_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(key_pins),
    .sync_out(key_sync)
  );

  // Mode and stop levels through two flops
  kri_sync #(.WIDTH(2)) u_mode_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(mode_pins),
    .sync_out(mode_sync)
  );

  // ==========================================================
  // Edge detection state
  logic key0_prev_ff; // Key zero last level
  logic keyor_prev_ff; // OR of keys one to four, last level
  logic key5_prev_ff; // Key five last level
  logic nxt_key0_prev;
  logic nxt_keyor_prev;
  logic nxt_key5_prev;
  logic key_or; // Combined keys one to four
  logic key_edge; // One-cycle key return event
  logic edge_sel; // Key five edge select

  // Combine and compare with last levels
  always_comb begin
    key_or = |key_sync[4:1];
    nxt_key0_prev = key_sync[0];
    nxt_keyor_prev = key_or;
    nxt_key5_prev = key_sync[5];
    key_edge = (key0_prev_ff & ~key_sync[0])
             | (keyor_prev_ff & ~key_or)
             | (edge_sel ? (~key5_prev_ff & key_sync[5])
                         : (key5_prev_ff & ~key_sync[5]));
  end

  // Register last levels, idle high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key0_prev_ff <= 1'b1;
      keyor_prev_ff <= 1'b1;
      key5_prev_ff <= 1'b1;
    end else begin
      key0_prev_ff <= nxt_key0_prev;
      keyor_prev_ff <= nxt_keyor_prev;
      key5_prev_ff <= nxt_key5_prev;
    end
  end

  // ==========================================================
  // Key return action: NMI or internal reset
  logic key_nmi_ff; // Pending key return NMI
  logic key_reset_ff; // Internal reset pulse
  logic nxt_key_nmi;
  logic nxt_key_reset;
  logic to_reset; // Event becomes a reset

  // Pick NMI or reset from mode pin and stop
  always_comb begin
    to_reset = key_edge & ~mode_sync[0] & mode_sync[1];
    nxt_key_reset = to_reset;
    nxt_key_nmi = key_nmi_ff;
    if (int_ack && key_nmi_ff) begin
      nxt_key_nmi = 1'b0; // Taken by core
    end
    if (key_edge && !to_reset) begin
      nxt_key_nmi = 1'b1;
    end
  end

  // Register action state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_nmi_ff <= 1'b0;
      key_reset_ff <= 1'b0;
    end else begin
      key_nmi_ff <= nxt_key_nmi;
      key_reset_ff <= nxt_key_reset;
    end
  end

  // ==========================================================
  // Edge control register and watchdog mode
  logic [7:0] edge_ctrl_ff; // Cause flag and edge select
  logic [7:0] nxt_edge_ctrl;
  logic wdt_nmi_mode_ff; // Watchdog overflow is non-maskable
  logic nxt_wdt_nmi_mode;
  logic wr_en; // Write accepted this cycle

  assign wr_en = avs_write & ~avs_waitrequest;
  assign edge_sel = edge_ctrl_ff[kri_pkg::EDGE_SEL_BIT];

  // Next edge control and mode
  always_comb begin
    nxt_edge_ctrl = edge_ctrl_ff;
    nxt_wdt_nmi_mode = wdt_nmi_mode_ff;
    if (wr_en && avs_address == kri_pkg::EDGE_CTRL_ADDR) begin
      nxt_edge_ctrl[kri_pkg::EDGE_SEL_BIT] = avs_writedata[kri_pkg::EDGE_SEL_BIT];
    end
    if (wr_en && avs_address == kri_pkg::CTRL_ADDR) begin
      nxt_wdt_nmi_mode = avs_writedata[0];
    end
  end

  // Key reset keeps select, other resets clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_nmi_mode_ff <= 1'b0;
      if (key_reset_seen) begin
        edge_ctrl_ff <= kri_pkg::EDGE_RESET;
        edge_ctrl_ff[kri_pkg::EDGE_CAUSE_BIT] <= 1'b1;
        edge_ctrl_ff[kri_pkg::EDGE_SEL_BIT] <= edge_ctrl_ff[kri_pkg::EDGE_SEL_BIT];
      end else begin
        edge_ctrl_ff <= kri_pkg::EDGE_RESET;
      end
    end else begin
      edge_ctrl_ff <= nxt_edge_ctrl;
      wdt_nmi_mode_ff <= nxt_wdt_nmi_mode;
    end
  end

  // ==========================================================
  // Maskable request and mask flags
  logic [10:0] req_ff; // Request flags, level 0 at bit 0
  logic [10:0] mask_ff; // Mask flags, set means disabled
  logic [10:0] nxt_req;
  logic [10:0] nxt_mask;
  logic [10:0] raw_req; // Incoming request pulses by level
  logic [10:0] ack_clr; // Flag cleared by acknowledge
  logic [10:0] pending; // Unmasked pending
  logic wdt_nmi; // Watchdog overflow as NMI
  logic wdt_nmi_ff; // Pending watchdog NMI
  logic nxt_wdt_nmi;

  // Level order fixes priority and vector
  always_comb begin
    raw_req[0] = watchdog_overflow_request & ~wdt_nmi_mode_ff;
    raw_req[1] = pin_edge_request_zero;
    raw_req[2] = pin_edge_request_one;
    raw_req[3] = timer_d_match_request;
    raw_req[4] = timer0_channel0_request;
    raw_req[5] = timer0_channel1_request;
    raw_req[6] = timer5_match_request;
    raw_req[7] = serial_receive_done_request | serial_3wire_done_request;
    raw_req[8] = serial_transmit_done_request;
    raw_req[9] = low_voltage_detect_request;
    raw_req[10] = nvm_write_done_request;
    wdt_nmi = watchdog_overflow_request & wdt_nmi_mode_ff;
  end

  // ==========================================================
  // Priority selection
  logic any_nmi; // Key or watchdog NMI pending
  logic [3:0] win_level; // Winning maskable level
  logic win_valid; // Some maskable request eligible
  logic [15:0] nxt_vector;
  logic nxt_int_req;

  // Lowest level wins; NMI bypasses masks and enable
  always_comb begin
    pending = req_ff & ~mask_ff;
    win_valid = 1'b0;
    win_level = 4'h0;
    for (int i = kri_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win_valid = 1'b1;
        win_level = 4'(i);
      end
    end
    any_nmi = key_nmi_ff | wdt_nmi_ff;
    nxt_int_req = any_nmi | (win_valid & int_enable);
    if (key_nmi_ff) begin
      nxt_vector = kri_pkg::VEC_KEY_NMI;
    end else if (wdt_nmi_ff) begin
      nxt_vector = kri_pkg::VEC_WATCHDOG;
    end else if (win_valid && int_enable) begin
      nxt_vector = kri_pkg::VEC_BASE + kri_pkg::VEC_STEP * 16'(win_level);
    end else begin
      nxt_vector = kri_pkg::VEC_NONE;
    end
  end

  // Flag updates: set wins over clear
  always_comb begin
    ack_clr = '0;
    if (int_ack && !any_nmi && win_valid) begin
      ack_clr[win_level] = 1'b1;
    end
    nxt_req = (req_ff & ~ack_clr) | raw_req;
    nxt_mask = mask_ff;
    nxt_wdt_nmi = wdt_nmi_ff;
    if (int_ack && !key_nmi_ff && wdt_nmi_ff) begin
      nxt_wdt_nmi = 1'b0;
    end
    if (wdt_nmi) begin
      nxt_wdt_nmi = 1'b1;
    end
    if (wr_en) begin
      unique case (avs_address)
        kri_pkg::REQ_LO_ADDR: nxt_req[7:0] = avs_writedata | raw_req[7:0];
        kri_pkg::REQ_HI_ADDR: nxt_req[10:8] = avs_writedata[2:0] | raw_req[10:8];
        kri_pkg::MASK_LO_ADDR: nxt_mask[7:0] = avs_writedata;
        kri_pkg::MASK_HI_ADDR: nxt_mask[10:8] = avs_writedata[2:0];
        default: begin
          nxt_mask = mask_ff; // Other addresses leave flags
        end
      endcase
    end
  end

  // Register flags and core outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_ff <= kri_pkg::REQ_RESET;
      mask_ff <= kri_pkg::MASK_RESET;
      wdt_nmi_ff <= 1'b0;
      int_req <= 1'b0;
      int_vector <= kri_pkg::VEC_NONE;
      standby_release <= 1'b0;
      key_reset_out <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      mask_ff <= nxt_mask;
      wdt_nmi_ff <= nxt_wdt_nmi;
      int_req <= nxt_int_req;
      int_vector <= nxt_vector;
      // Same state as int_req, so an offer never outlives its standby release
      standby_release <= (|req_ff) | any_nmi;
      key_reset_out <= key_reset_ff;
    end
  end

  // ==========================================================
  // Bus read path: one wait cycle per access
  logic wait_ff; // Low in the answer cycle
  logic nxt_wait;
  logic [7:0] nxt_rdata;

  // Decode read data and waitrequest
  always_comb begin
    nxt_wait = ~((avs_read | avs_write) & avs_waitrequest);
    nxt_rdata = 8'h00;
    unique case (avs_address)
      kri_pkg::EDGE_CTRL_ADDR: nxt_rdata = edge_ctrl_ff;
      kri_pkg::REQ_LO_ADDR: nxt_rdata = req_ff[7:0];
      kri_pkg::REQ_HI_ADDR: nxt_rdata = {5'h00, req_ff[10:8]};
      kri_pkg::MASK_LO_ADDR: nxt_rdata = mask_ff[7:0];
      kri_pkg::MASK_HI_ADDR: nxt_rdata = {5'h00, mask_ff[10:8]};
      kri_pkg::CTRL_ADDR: nxt_rdata = {7'h00, wdt_nmi_mode_ff};
      default: nxt_rdata = 8'h00; // Unmapped reads zero
    endcase
  end

  // Register bus outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
      avs_readdata <= 8'h00;
    end else begin
      wait_ff <= nxt_wait;
      avs_readdata <= nxt_rdata;
    end
  end

  assign avs_waitrequest = wait_ff;
endmodule

// ### kri_pkg.sv
// Constants for the key return and interrupt source controller.
// Assumes a 16-bit byte-addressed register space and a core that
// acknowledges one vector at a time.
package kri_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [15:0] EDGE_CTRL_ADDR = 16'hff90; // Key return edge control
  localparam logic [15:0] REQ_LO_ADDR = 16'hffe0; // Request flags 7..0
  localparam logic [15:0] REQ_HI_ADDR = 16'hffe1; // Request flags 10..8
  localparam logic [15:0] MASK_LO_ADDR = 16'hffe4; // Mask flags 7..0
  localparam logic [15:0] MASK_HI_ADDR = 16'hffe5; // Mask flags 10..8
  localparam logic [15:0] CTRL_ADDR = 16'hffe8; // Watchdog mode select
  // ==========================================================
  // Field positions and reset values
  localparam int EDGE_CAUSE_BIT = 7; // Reset-cause flag
  localparam int EDGE_SEL_BIT = 0; // Key five edge select
  localparam logic [7:0] EDGE_RESET = 8'h00; // Edge control after other resets
  localparam int NUM_MASKABLE = 11; // Two external, nine internal
  localparam int NUM_SOURCES = 13; // All sources counted
  localparam int HI_BITS = 3; // Flags held in the high byte
  localparam logic [10:0] MASK_RESET = 11'h7ff; // All masked
  localparam logic [10:0] REQ_RESET = 11'h000; // None pending
  // ==========================================================
  // Vector table addresses
  localparam logic [15:0] VEC_KEY_NMI = 16'h0002;
  localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
  localparam logic [15:0] VEC_BASE = 16'h0004; // Maskable level 0 vector
  localparam logic [15:0] VEC_STEP = 16'h0002; // Vector spacing per level
  localparam logic [15:0] VEC_NONE = 16'h0000; // No request pending
endpackage

// ### kri_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes the inputs are static relative to clk for two edges.
`timescale 1ns/100ps
module kri_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pin side
  input wire logic [WIDTH-1:0] async_in,
  // Synchronised side
  output logic [WIDTH-1:0] sync_out
);
  // ==========================================================
  // Synchroniser flops
  logic [WIDTH-1:0] meta_ff; // First stage, read only by second
  logic [WIDTH-1:0] sync_ff; // Second stage
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // Next values, idle high like released keys
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Register both stages
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ### kri_ctrl_sva.sv
// Port checker for the key return and interrupt source controller.
// Assumes it is bound onto kri_ctrl and that all ports share clk.
`timescale 1ns/100ps
module kri_ctrl_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Key control pins
  input wire logic key_return_mode_pin,
  input wire logic stop_mode,
  // Core side
  input wire logic int_ack,
  input wire logic int_req,
  input wire logic [15:0] int_vector,
  input wire logic standby_release,
  input wire logic key_reset_out
);
  // ==========
  // Shared clock and reset for every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Bus answers after one wait cycle, for one cycle only
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  // Outputs quiet right after reset
  chk_reset_quiet: assert property ($fell(sys_rst) |-> !int_req && !key_reset_out)
    else $error("request offered straight after reset");
  // Offered vector is one of the table entries
  chk_vec_legal: assert property (int_req |-> !int_vector[0] && int_vector >= 16'h0002 && int_vector <= 16'h0018)
    else $error("vector outside table");
  // Any offered request also releases standby
  chk_standby_req: assert property (int_req |-> standby_release)
    else $error("request without standby release");
  // Key NMI stays offered until taken, nothing displaces it
  chk_nmi_hold: assert property (int_req && int_vector == kri_pkg::VEC_KEY_NMI && !int_ack && !$past(int_ack)
    |=> int_req && int_vector == kri_pkg::VEC_KEY_NMI)
    else $error("key NMI dropped or displaced");
  // Internal reset only with mode pin low in stop
  chk_reset_mode: assert property (key_reset_out |-> !key_return_mode_pin && stop_mode)
    else $error("key reset outside stop with mode low");
  // One edge gives a one-cycle reset pulse
  chk_reset_single: assert property (key_reset_out |=> !key_reset_out)
    else $error("key reset pulse too long");
endmodule

bind kri_ctrl kri_ctrl_sva chk_u (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .key_return_mode_pin(key_return_mode_pin), .stop_mode(stop_mode), .int_ack(int_ack),
  .int_req(int_req), .int_vector(int_vector), .standby_release(standby_release),
  .key_reset_out(key_reset_out));

// ### kri_core.sv
// Behavioural processor core that takes offered interrupts.
// Assumes the controller samples int_ack on the next rising edge.
`timescale 1ns/100ps
module kri_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Controller side
  input wire logic int_req,
  input wire logic [15:0] int_vector,
  output logic int_ack,
  // Bench side
  input wire logic [3:0] lag,
  output logic taken,
  output logic [15:0] taken_vec
);
  int wait_n; // Cycles waited on the current offer
  int gap_n; // Settling time after an acknowledge
  // ==========
  // Acknowledge after lag cycles, then let the flag clear
  initial begin
    int_ack = 1'b0;
    taken = 1'b0;
    taken_vec = 16'h0000;
  end
  always @(posedge clk) begin
    int_ack <= 1'b0;
    taken <= int_ack;
    // Vector taken where the controller sees the acknowledge
    if (int_ack) taken_vec <= int_vector;
    if (sys_rst) begin
      wait_n <= 0;
      gap_n <= 0;
    end else if (gap_n > 0) begin
      gap_n <= gap_n - 1;
    end else if (int_req && !int_ack) begin
      if (wait_n >= lag) begin
        int_ack <= 1'b1;
        wait_n <= 0;
        gap_n <= 3;
      end else wait_n <= wait_n + 1;
    end
  end
endmodule

// ### key_return_and_interrupt_sources_tb.sv
// Self-checking bench for the interrupt controller and key return logic.
// Assumes kri_ctrl, kri_core and the bound checker are compiled before it.
`timescale 1ns/100ps
module key_return_and_interrupt_sources_tb;
  logic clk, sys_rst, key_reset_seen, avs_read, avs_write, avs_waitrequest;
  logic [15:0] avs_address, int_vector, taken_vec;
  logic [7:0] avs_writedata, avs_readdata, q;
  logic mode, stop, int_ack, int_enable, int_req, standby, krst, taken;
  logic [5:0] keys; // Key pins, idle high
  logic [11:0] req, rq; // Peripheral request pulses, next random mix
  logic [3:0] lag; // Core answer delay
  logic [10:0] mask, pend;
  logic [15:0] expq[$]; // Expected vectors in order
  int fails, n_compared, seed, n_krst, i, r;
  // ==========
  // Design, core model and clock
  kri_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .key_reset_seen(key_reset_seen),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .key_return_mode_pin(mode),
    .key_input_zero(keys[0]), .key_input_one(keys[1]), .key_input_two(keys[2]),
    .key_input_three(keys[3]), .key_input_four(keys[4]), .key_input_five(keys[5]),
    .stop_mode(stop), .watchdog_overflow_request(req[0]), .pin_edge_request_zero(req[1]),
    .pin_edge_request_one(req[2]), .timer_d_match_request(req[3]),
    .timer0_channel0_request(req[4]), .timer0_channel1_request(req[5]),
    .timer5_match_request(req[6]), .serial_receive_done_request(req[7]),
    .serial_3wire_done_request(req[8]), .serial_transmit_done_request(req[9]),
    .low_voltage_detect_request(req[10]), .nvm_write_done_request(req[11]),
    .int_ack(int_ack), .int_enable(int_enable), .int_req(int_req),
    .int_vector(int_vector), .standby_release(standby), .key_reset_out(krst));
  kri_core core_u (.clk(clk), .sys_rst(sys_rst), .int_req(int_req),
    .int_vector(int_vector), .int_ack(int_ack), .lag(lag), .taken(taken),
    .taken_vec(taken_vec));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // Shared tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) fails++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({8'h00, q}, {8'h00, e});
  endtask
  // Wait until every expected vector was taken, then look for extras
  task drain;
    int n;
    n = 0;
    while (expq.size() != 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) fails++;
    repeat (10) @(posedge clk);
  endtask
  task pulse(input logic [11:0] b);
    req <= b;
    @(posedge clk);
    req <= 12'h000;
  endtask
  // Key pin change; one NMI expected when ev is set
  task key_step(input logic [5:0] v, input bit ev);
    if (ev) expq.push_back(kri_pkg::VEC_KEY_NMI);
    keys <= v;
    repeat (12) @(posedge clk);
    drain();
  endtask
  function automatic int lvl(input int b);
    return (b < 8) ? b : b - 1;
  endfunction
  // ==========
  // Every vector taken by the core is compared with the model
  always @(posedge clk) begin
    if (taken === 1'b1) begin
      if (expq.size() == 0) check(taken_vec, 16'hffff);
      else check(taken_vec, expq.pop_front());
    end
    if (krst === 1'b1) n_krst++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
  // ==========
  // Main sequence
  initial begin
    {sys_rst, key_reset_seen, avs_read, avs_write, mode, stop, int_enable} = 7'h40;
    avs_address = 16'h0000;
    avs_writedata = 8'h00;
    keys = 6'h3f;
    req = 12'h000;
    lag = 4'h0;
    fails = 0;
    n_compared = 0;
    n_krst = 0;
    seed = 34;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(16'hff90, 8'h00);
    rd(16'hffe0, 8'h00);
    rd(16'hffe4, 8'hff);
    rd(16'hffe5, 8'h07);
    rd(16'h1234, 8'h00);
    bus(1'b1, 16'hff90, 8'hff);
    rd(16'hff90, 8'h01);
    bus(1'b1, 16'hff90, 8'h00);
    // Random mask and request mixes, served by priority
    int_enable <= 1'b1;
    for (r = 0; r < 14; r++) begin
      mask = $random(seed);
      lag <= $random(seed);
      bus(1'b1, 16'hffe4, mask[7:0]);
      bus(1'b1, 16'hffe5, {5'h00, mask[10:8]});
      pend = 11'h000;
      rq = $random(seed);
      for (i = 0; i < 12; i++) if (rq[i]) pend[lvl(i)] = 1'b1;
      for (i = 0; i < 11; i++) if (pend[i] && !mask[i]) expq.push_back(16'h0004 + 2 * i);
      pulse(rq);
      drain();
      check(standby, |(pend & mask));
      rd(16'hffe0, pend[7:0] & mask[7:0]);
      rd(16'hffe1, {5'h00, pend[10:8] & mask[10:8]});
      bus(1'b1, 16'hffe0, 8'h00);
      bus(1'b1, 16'hffe1, 8'h00);
    end
    // Watchdog as NMI ignores the global enable and wins
    bus(1'b1, 16'hffe4, 8'h00);
    bus(1'b1, 16'hffe8, 8'h01);
    int_enable <= 1'b0;
    expq.push_back(16'h0004);
    pulse(12'h003);
    drain();
    check(standby, 1'b1);
    expq.push_back(16'h0006);
    int_enable <= 1'b1;
    drain();
    bus(1'b1, 16'hffe8, 8'h00);
    // Key edges with mode high and maskable service off
    int_enable <= 1'b0;
    mode <= 1'b1;
    repeat (4) @(posedge clk);
    key_step(6'h3e, 1);
    key_step(6'h3f, 0);
    key_step(6'h21, 1);
    key_step(6'h20, 1);
    key_step(6'h3f, 0);
    key_step(6'h1f, 1);
    key_step(6'h3f, 0);
    bus(1'b1, 16'hff90, 8'h01);
    key_step(6'h1f, 0);
    key_step(6'h3f, 1);
    // Mode low: NMI outside stop, internal reset in stop
    mode <= 1'b0;
    repeat (4) @(posedge clk);
    key_step(6'h3e, 1);
    key_step(6'h3f, 0);
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    key_step(6'h3e, 0);
    key_step(6'h3f, 0);
    check(n_krst, 1);
    stop <= 1'b0;
    mode <= 1'b1;
    // Key return reset keeps select, other reset clears all
    sys_rst <= 1'b1;
    key_reset_seen <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    key_reset_seen <= 1'b0;
    rd(16'hff90, 8'h81);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(16'hff90, 8'h00);
    stop_test();
  end
endmodule
